// ---- logic/tcs_ctrl.sv ----
// Control and status of a down-counting timer: run/halt, active flag, event flags, interrupt.
// Assumes count_tick and underflow come from the counter datapath on sys_clk;
// timer_io_pin comes from outside and is synchronised here.
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps

module tcs_ctrl (
	// clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// register port
	input wire tcs_pkg::tcs_req_t req,
	output logic [7:0] rdata,
	// counter datapath
	input wire logic count_tick,
	input wire logic underflow,
	output logic count_enable,
	output logic pulse_out,
	input wire logic pulse_toggle,
	// external input
	input wire logic timer_io_pin,
	// interrupt
	output logic irq
);
	import tcs_pkg::*;

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	function automatic logic hit(input tcs_req_t r, input logic [7:0] a);
		return r.addr == a;
	endfunction

	logic wr_ctrl;
	logic halt_wr;
	assign wr_ctrl = req.wr && hit(req, TCS_ADDR_CTRL);
	assign halt_wr = wr_ctrl && req.wdata[TCS_B_HALT];

	// ----------------------------------------------------------------
	// run request
	// ----------------------------------------------------------------
	logic run_q;
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			run_q <= 1'b0;
		end else if (halt_wr) begin
			run_q <= 1'b0;
		end else if (wr_ctrl) begin
			run_q <= req.wdata[TCS_B_RUN];
		end
	end

	// ----------------------------------------------------------------
	// active flag follows run request on the count tick
	// ----------------------------------------------------------------
	tcs_state_t st_q;
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			st_q <= TCS_ST_IDLE;
		end else if (halt_wr) begin
			st_q <= TCS_ST_IDLE;
		end else begin
			case (st_q)
				TCS_ST_IDLE: begin
					if (run_q && count_tick) begin
						st_q <= TCS_ST_RUN;
					end
				end
				TCS_ST_RUN: begin
					if (!run_q && count_tick) begin
						st_q <= TCS_ST_IDLE;
					end else if (!run_q) begin
						st_q <= TCS_ST_STOPPING;
					end
				end
				TCS_ST_STOPPING: begin
					if (run_q) begin
						st_q <= TCS_ST_RUN;
					end else if (count_tick) begin
						st_q <= TCS_ST_IDLE;
					end
				end
				default: begin
					st_q <= TCS_ST_IDLE;
				end
			endcase
		end
	end

	logic active;
	assign active = (st_q == TCS_ST_RUN) || (st_q == TCS_ST_STOPPING);
	// counting stops at once on halt or a zero request
	assign count_enable = active && run_q && !halt_wr;

	// ----------------------------------------------------------------
	// pulse output level
	// ----------------------------------------------------------------
	logic pulse_q;
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			pulse_q <= 1'b0;
		end else if (halt_wr) begin
			pulse_q <= 1'b0;
		end else if (count_enable && pulse_toggle) begin
			pulse_q <= !pulse_q;
		end
	end
	assign pulse_out = pulse_q;

	// ----------------------------------------------------------------
	// mode register and pin input
	// ----------------------------------------------------------------
	tcs_mode_t mode_q;
	logic edge_pol_q;
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			mode_q <= TCS_MODE_TIMER;
			edge_pol_q <= 1'b0;
		end else if (req.wr && hit(req, TCS_ADDR_MODE)) begin
			mode_q <= tcs_mode_t'(req.wdata[1:0]);
			edge_pol_q <= req.wdata[2];
		end
	end

	// two stages before use; the second and a third delay stage are read
	logic pin_s1_q;
	logic pin_s2_q;
	logic pin_d_q;
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			pin_s1_q <= 1'b0;
			pin_s2_q <= 1'b0;
			pin_d_q <= 1'b0;
		end else begin
			pin_s1_q <= timer_io_pin;
			pin_s2_q <= pin_s1_q;
			pin_d_q <= pin_s2_q;
		end
	end

	// edge_pol 0: active level high, rising is the period edge
	logic act_lvl;
	logic act_lvl_d;
	assign act_lvl = pin_s2_q ^ edge_pol_q;
	assign act_lvl_d = pin_d_q ^ edge_pol_q;

	logic edge_evt;
	always_comb begin
		edge_evt = 1'b0;
		if (active) begin
			case (mode_q)
				TCS_MODE_WIDTH: edge_evt = act_lvl_d && !act_lvl;
				TCS_MODE_PERIOD: edge_evt = act_lvl && !act_lvl_d;
				default: edge_evt = 1'b0;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// event flags, write zero to clear
	// ----------------------------------------------------------------
	logic edge_q;
	logic wrap_q;
	logic clr_edge;
	logic clr_wrap;
	assign clr_edge = wr_ctrl && !req.wdata[TCS_B_EDGE];
	assign clr_wrap = wr_ctrl && !req.wdata[TCS_B_WRAP];

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			edge_q <= 1'b0;
		end else if (edge_evt) begin
			edge_q <= 1'b1;
		end else if (clr_edge) begin
			edge_q <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			wrap_q <= 1'b0;
		end else if (underflow) begin
			wrap_q <= 1'b1;
		end else if (clr_wrap) begin
			wrap_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// interrupt mask and output
	// ----------------------------------------------------------------
	logic [7:0] imask_q;
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			imask_q <= TCS_IMASK_RESET;
		end else if (req.wr && hit(req, TCS_ADDR_IMASK)) begin
			imask_q <= req.wdata & TCS_FLAG_MASK;
		end
	end

	logic [7:0] ctrl_view;
	always_comb begin
		ctrl_view = TCS_CTRL_RESET;
		ctrl_view[TCS_B_RUN] = run_q;
		ctrl_view[TCS_B_ACTIVE] = active;
		ctrl_view[TCS_B_HALT] = 1'b0;
		ctrl_view[TCS_B_EDGE] = edge_q;
		ctrl_view[TCS_B_WRAP] = wrap_q;
	end

	assign irq = |(ctrl_view & imask_q);

	// ----------------------------------------------------------------
	// read data, one cycle after the strobe
	// ----------------------------------------------------------------
	logic [7:0] rdata_q;
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rdata_q <= 8'h00;
		end else if (req.rd) begin
			if (hit(req, TCS_ADDR_CTRL)) begin
				rdata_q <= ctrl_view;
			end else if (hit(req, TCS_ADDR_IMASK)) begin
				rdata_q <= imask_q;
			end else if (hit(req, TCS_ADDR_MODE)) begin
				rdata_q <= {5'h00, edge_pol_q, mode_q};
			end else begin
				rdata_q <= 8'h00;
			end
		end else begin
			rdata_q <= 8'h00;
		end
	end
	assign rdata = rdata_q;

	// ----------------------------------------------------------------
	// checks: run request and active flag
	// ----------------------------------------------------------------
	run_write_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		wr_ctrl && !halt_wr |=> run_q == $past(req.wdata[TCS_B_RUN]))
		else $error("run request not taken from write");
	run_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		!wr_ctrl |=> $stable(run_q))
		else $error("run request changed without write");
	zero_stop_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		!run_q |-> !count_enable)
		else $error("counting without run request");
	active_tick_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		$rose(active) |-> $past(count_tick) && $past(run_q))
		else $error("active flag rose without tick");
	active_set_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		!active && run_q && count_tick && !halt_wr |=> active)
		else $error("active flag missed tick");
	active_clear_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		$fell(active) |-> $past(count_tick) || $past(halt_wr))
		else $error("active flag fell off tick");
	active_stop_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		active && !run_q && count_tick && !halt_wr |=> !active)
		else $error("active flag kept after stop tick");
	active_keep_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		active && !count_tick && !halt_wr |=> active)
		else $error("active flag fell between ticks");

	// ----------------------------------------------------------------
	// checks: forced halt
	// ----------------------------------------------------------------
	halt_stop_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		halt_wr |-> !count_enable ##1 (!run_q && !active && !pulse_out))
		else $error("forced halt did not stop");
	halt_read_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		req.rd && hit(req, TCS_ADDR_CTRL) |=> !rdata[TCS_B_HALT] && !rdata[3]
			&& rdata[7:6] == 2'h0)
		else $error("reserved or halt bit read nonzero");
	pulse_keep_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		!count_enable && !halt_wr |=> $stable(pulse_out))
		else $error("pulse output moved while stopped");

	// ----------------------------------------------------------------
	// checks: event flags
	// ----------------------------------------------------------------
	edge_set_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		active && mode_q == TCS_MODE_PERIOD && act_lvl && !act_lvl_d |=> edge_q)
		else $error("period edge not flagged");
	width_set_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		active && mode_q == TCS_MODE_WIDTH && !act_lvl && act_lvl_d |=> edge_q)
		else $error("width end not flagged");
	edge_quiet_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		!edge_q && !edge_evt |=> !edge_q)
		else $error("edge flag set without event");
	wrap_set_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		underflow |=> wrap_q)
		else $error("underflow not flagged");
	flag_keep_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		wrap_q && !(wr_ctrl && !req.wdata[TCS_B_WRAP]) |=> wrap_q)
		else $error("wrap flag lost without zero write");
	edge_keep_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		edge_q && !clr_edge |=> edge_q)
		else $error("edge flag lost without zero write");
	edge_clear_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		edge_q && clr_edge && !edge_evt |=> !edge_q)
		else $error("edge flag kept after zero write");
	wrap_clear_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		wrap_q && clr_wrap && !underflow |=> !wrap_q)
		else $error("wrap flag kept after zero write");
	edge_clash_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		edge_evt && clr_edge |=> edge_q)
		else $error("edge event lost to clear");
	wrap_clash_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		underflow && clr_wrap |=> wrap_q)
		else $error("underflow lost to clear");

	// ----------------------------------------------------------------
	// checks: register port and interrupt
	// ----------------------------------------------------------------
	rdata_idle_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		!req.rd |=> rdata == 8'h00)
		else $error("read data outside read slot");
	irq_level_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		imask_q[TCS_B_WRAP] && wrap_q |-> irq)
		else $error("interrupt missing");
	irq_edge_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		imask_q[TCS_B_EDGE] && edge_q |-> irq)
		else $error("edge interrupt missing");
	irq_quiet_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		!(imask_q[TCS_B_EDGE] && edge_q) && !(imask_q[TCS_B_WRAP] && wrap_q) |-> !irq)
		else $error("interrupt without unmasked flag");

	// ----------------------------------------------------------------
	// covers
	// ----------------------------------------------------------------
	start_run_c: cover property (@(posedge sys_clk) disable iff (!nrst) $rose(run_q) ##[1:20] active);
	halt_c: cover property (@(posedge sys_clk) disable iff (!nrst) active && halt_wr);
	period_c: cover property (@(posedge sys_clk) disable iff (!nrst) $rose(edge_q));
	clash_c: cover property (@(posedge sys_clk) disable iff (!nrst) underflow && clr_wrap);
	width_c: cover property (@(posedge sys_clk) disable iff (!nrst) mode_q == TCS_MODE_WIDTH && edge_evt);

endmodule // tcs_ctrl

// ---- logic/tcs_pkg.sv ----
// Package for the timer count control/status block: register map, fields, reset values, modes.
// Assumes an 8-bit register port with three registers at fixed offsets.
package tcs_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [7:0] TCS_ADDR_CTRL = 8'hDA;
	localparam logic [7:0] TCS_ADDR_IMASK = 8'hDB;
	localparam logic [7:0] TCS_ADDR_MODE = 8'hDC;
	localparam logic [7:0] TCS_CTRL_RESET = 8'h00;
	localparam logic [7:0] TCS_IMASK_RESET = 8'h00;
	localparam logic [1:0] TCS_MODE_RESET = 2'h0;

	// ----------------------------------------------------------------
	// field positions in timer_control_status
	// ----------------------------------------------------------------
	localparam int TCS_B_RUN = 0;
	localparam int TCS_B_ACTIVE = 1;
	localparam int TCS_B_HALT = 2;
	localparam int TCS_B_EDGE = 4;
	localparam int TCS_B_WRAP = 5;
	// interrupt mask bits share the flag positions
	localparam logic [7:0] TCS_FLAG_MASK = 8'h30;

	// ----------------------------------------------------------------
	// timer and measurement modes
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		TCS_MODE_TIMER = 2'h0,
		TCS_MODE_WIDTH = 2'h1,
		TCS_MODE_PERIOD = 2'h2
	} tcs_mode_t;

	// sync state machine of the active flag, one-hot
	typedef enum logic [2:0] {
		TCS_ST_IDLE = 3'h1,
		TCS_ST_RUN = 3'h2,
		TCS_ST_STOPPING = 3'h4
	} tcs_state_t;

	// register port request
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} tcs_req_t;

endpackage

// ---- verification/tcs_pulse_src.sv ----
// Pulse source model standing on the timer input pin.
// Assumes the bench calls drive() from its main sequence, once at time zero for the idle level.
`timescale 1ns/1ps

module tcs_pulse_src (
	// clock
	input wire logic sys_clk,
	// external pin
	output logic pin
);
	// dly lets the source change promptly or late
	task automatic drive(input logic lvl, input int dly);
		repeat (dly) @(posedge sys_clk);
		pin <= lvl;
	endtask
endmodule // tcs_pulse_src

// ---- verification/test_timer_count_control_status.sv ----
// Self-checking bench for the timer control/status block.
// Assumes the register map and reset values of tcs_pkg.
`timescale 1ns/1ps

module test_timer_count_control_status;
	import tcs_pkg::*;
	logic sys_clk, nrst, count_tick, underflow, pulse_toggle, pin, rd_seen;
	logic count_enable, pulse_out, irq;
	logic [7:0] rdata;
	logic [31:0] seed;
	tcs_req_t req;
	logic [7:0] exp_q[$];
	int n_fail, tests_run, m;

	tcs_ctrl u_dut (.sys_clk(sys_clk), .nrst(nrst), .req(req), .rdata(rdata),
		.count_tick(count_tick), .underflow(underflow), .count_enable(count_enable),
		.pulse_out(pulse_out), .pulse_toggle(pulse_toggle), .timer_io_pin(pin), .irq(irq));
	tcs_pulse_src u_src (.sys_clk(sys_clk), .pin(pin));

	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			$display("wrong value %s expected %h seen %h", nm, e, g);
			n_fail++;
		end
	endtask

	task automatic give_verdict();
		if (n_fail == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// one strobe cycle; datapath events ride on the same edge
	task automatic bus(input logic [7:0] a, d, input logic [1:0] s, input logic [2:0] e);
		@(posedge sys_clk);
		req <= '{addr: a, wdata: d, wr: s[1], rd: s[0]};
		{count_tick, underflow, pulse_toggle} <= e;
		@(posedge sys_clk);
		req <= '0;
		{count_tick, underflow, pulse_toggle} <= 3'h0;
		#1;
	endtask

	task automatic wr(input logic [7:0] a, d);
		bus(a, d, 2'h2, 3'h0);
	endtask

	task automatic rd(input logic [7:0] a, e);
		exp_q.push_back(e);
		bus(a, 8'h00, 2'h1, 3'h0);
	endtask

	task automatic ev(input logic [2:0] e);
		bus(8'h00, 8'h00, 2'h0, e);
	endtask

	// read data stand only in the cycle after the strobe
	always @(posedge sys_clk) begin
		if (rd_seen && exp_q.size() > 0)
			chk("rdata", exp_q.pop_front(), rdata);
		rd_seen <= req.rd;
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		req = '0;
		nrst = 1'b0;
		{count_tick, underflow, pulse_toggle} = 3'h0;
		n_fail = 0;
		tests_run = 0;
		seed = 32'hDDC135B8;
		u_src.drive(1'b0, 0);
		repeat (20) @(posedge sys_clk);
		nrst <= 1'b1;
		rd(TCS_ADDR_CTRL, TCS_CTRL_RESET);
		rd(TCS_ADDR_IMASK, TCS_IMASK_RESET);
		rd(TCS_ADDR_MODE, 8'h00);
		rd(8'hDD, 8'h00);
		repeat (4) begin
			seed = lfsr(seed);
			wr(TCS_ADDR_IMASK, seed[7:0]);
			rd(TCS_ADDR_IMASK, seed[7:0] & TCS_FLAG_MASK);
		end
		wr(TCS_ADDR_IMASK, TCS_FLAG_MASK);
		wr(TCS_ADDR_CTRL, 8'h01);
		rd(TCS_ADDR_CTRL, 8'h01);
		ev(3'h4);
		rd(TCS_ADDR_CTRL, 8'h03);
		chk("count_enable", 8'h01, {7'h00, count_enable});
		ev(3'h1);
		chk("pulse_out", 8'h01, {7'h00, pulse_out});
		ev(3'h2);
		rd(TCS_ADDR_CTRL, 8'h23);
		chk("irq", 8'h01, {7'h00, irq});
		wr(TCS_ADDR_CTRL, 8'h31);
		rd(TCS_ADDR_CTRL, 8'h23);
		wr(TCS_ADDR_CTRL, 8'h01);
		rd(TCS_ADDR_CTRL, 8'h03);
		chk("irq", 8'h00, {7'h00, irq});
		bus(TCS_ADDR_CTRL, 8'h01, 2'h2, 3'h2);
		rd(TCS_ADDR_CTRL, 8'h23);
		wr(TCS_ADDR_CTRL, 8'h00);
		rd(TCS_ADDR_CTRL, 8'h02);
		ev(3'h4);
		rd(TCS_ADDR_CTRL, 8'h00);
		chk("count_enable", 8'h00, {7'h00, count_enable});
		// width mode flags on the falling level, period mode on the rising edge
		for (m = 1; m < 3; m++) begin
			wr(TCS_ADDR_MODE, m[7:0]);
			wr(TCS_ADDR_CTRL, 8'h01);
			ev(3'h4);
			u_src.drive(1'b1, m);
			repeat (6) @(posedge sys_clk);
			rd(TCS_ADDR_CTRL, m == 2 ? 8'h13 : 8'h03);
			u_src.drive(1'b0, 0);
			repeat (6) @(posedge sys_clk);
			rd(TCS_ADDR_CTRL, 8'h13);
		end
		// inverted polarity: the falling pin is the period edge
		wr(TCS_ADDR_MODE, 8'h06);
		rd(TCS_ADDR_MODE, 8'h06);
		wr(TCS_ADDR_CTRL, 8'h01);
		u_src.drive(1'b1, 0);
		repeat (6) @(posedge sys_clk);
		rd(TCS_ADDR_CTRL, 8'h03);
		u_src.drive(1'b0, 1);
		repeat (6) @(posedge sys_clk);
		rd(TCS_ADDR_CTRL, 8'h13);
		wr(TCS_ADDR_CTRL, 8'h35);
		rd(TCS_ADDR_CTRL, 8'h10);
		chk("pulse_out", 8'h00, {7'h00, pulse_out});
		chk("count_enable", 8'h00, {7'h00, count_enable});
		chk("irq", 8'h01, {7'h00, irq});
		for (int i = 0; i < 8 && exp_q.size() > 0; i++)
			@(posedge sys_clk);
		if (exp_q.size() > 0)
			n_fail++;
		give_verdict();
	end
endmodule // test_timer_count_control_status
